// File: src/mdp_dev.sv
/*
  Device end of the memory data port: register file, routing of port data
  into display, gamma, cursor and palette memories, character code stream.
  Assumes a host that keeps the host-side duties of the port protocol.
*/
// How it works
// - Port bytes go to the selected memory
// - Back-to-back port writes need no re-addressing
// - Back-to-back port reads stream display or gamma memory
// - Display writes follow width, format, depth, block
// - Host sets active window before pattern loads
// - Host uses block canvas for glyph writes
// - Char codes: low byte only, high first
// - Codes from 8000h are full size
// - Gamma select write clears gamma counter
// - Cursor select write clears cursor counter
// - Host loads palette in one 128-byte run
// - First read after readdressing returns dummy
// - Cursor and palette are write-only
// - Reads fetch 4-byte aligned words
// - Host waits FIFO empty before readdressing
// - Two-bit field picks port destination
// - Cursor RAM: four sets of 128x16
module mdp_dev #(
  parameter int DAW = 12
) (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RSTN,
  // Host bus
  mdp_if.dev BUS,
  // Character code stream
  output logic CHAR_STB,
  output logic [15:0] CHAR_CODE,
  output logic CHAR_FULL
);
  typedef struct packed {
    logic [7:0] inctl;
    logic [7:0] cfg;
    logic [1:0] gam_sel;
    logic [1:0] cur_sel;
    logic [15:0] disp_ptr;
    logic [7:0] gam_ptr;
    logic [7:0] cur_ptr;
    logic [6:0] pal_ptr;
    logic primed;
    logic hi_pend;
    logic [7:0] hi_byte;
    logic [15:0] rdata;
    logic char_stb;
    logic [15:0] char_code;
    logic char_full;
  } mdp_dev_st_t;

  mdp_dev_st_t st_r;
  mdp_dev_st_t st_nxt;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [1:0] bytes_per_access(input logic [7:0] cfg);
    if (cfg[mdp_pkg::CFG_BUS16_BIT] &&
        cfg[mdp_pkg::CFG_DEPTH_LSB +: 2] != mdp_pkg::DEPTH_8BPP) begin
      return 2'h2;
    end
    return 2'h1;
  endfunction

  function automatic logic [15:0] pick_pair(input logic [31:0] w, input logic [1:0] ofs,
                                            input logic swap);
    logic [7:0] lo;
    logic [7:0] hi;
    lo = w[8*ofs +: 8];
    hi = w[8*(2'(ofs + 2'h1)) +: 8];
    return swap ? {lo, hi} : {hi, lo};
  endfunction

  // ****************************************
  // Memories
  // ****************************************
  logic [1:0] disp_we;
  logic [1:0] gam_we;
  logic [1:0] cur_we;
  logic [1:0] pal_we;
  logic [15:0] mem_wdata;
  logic [31:0] disp_word;
  logic [31:0] gam_word;
  logic [mdp_pkg::GAM_AW-1:0] gam_addr;
  logic [mdp_pkg::CUR_AW-1:0] cur_addr;

  assign gam_addr = {st_r.gam_sel, st_r.gam_ptr};
  assign cur_addr = {st_r.cur_sel, st_r.cur_ptr};

  mdp_ram #(.AW(DAW)) u_disp (
    .CLOCK(CLOCK),
    .WE(disp_we),
    .WADDR(st_r.disp_ptr[DAW-1:0]),
    .WDATA(mem_wdata),
    .RADDR(st_r.disp_ptr[DAW-1:2]),
    .RWORD(disp_word)
  );
  mdp_ram #(.AW(mdp_pkg::GAM_AW)) u_gamma (
    .CLOCK(CLOCK),
    .WE(gam_we),
    .WADDR(gam_addr),
    .WDATA(mem_wdata),
    .RADDR(gam_addr[mdp_pkg::GAM_AW-1:2]),
    .RWORD(gam_word)
  );
  // Four sets of 128 entries, two bytes per entry
  mdp_ram #(.AW(mdp_pkg::CUR_AW)) u_cursor (
    .CLOCK(CLOCK),
    .WE(cur_we),
    .WADDR(cur_addr),
    .WDATA(mem_wdata),
    .RADDR(cur_addr[mdp_pkg::CUR_AW-1:2]),
    .RWORD()
  );
  mdp_ram #(.AW(mdp_pkg::PAL_AW)) u_palette (
    .CLOCK(CLOCK),
    .WE(pal_we),
    .WADDR(st_r.pal_ptr),
    .WDATA(mem_wdata),
    .RADDR(st_r.pal_ptr[mdp_pkg::PAL_AW-1:2]),
    .RWORD()
  );

  // ****************************************
  // Next state
  // ****************************************
  mdp_pkg::mdp_dest_t dest;
  logic text_mode;
  logic [1:0] bpa;
  logic swap;

  assign dest = mdp_pkg::mdp_dest_t'(st_r.inctl[mdp_pkg::INCTL_DST_LSB +: 2]);
  // Linear canvas forces graphic mode
  assign text_mode = st_r.inctl[mdp_pkg::INCTL_TEXT_BIT] & st_r.cfg[mdp_pkg::CFG_BLOCK_BIT];
  assign bpa = bytes_per_access(st_r.cfg);
  assign swap = st_r.cfg[mdp_pkg::CFG_SWAP_BIT];

  always_comb begin
    logic [15:0] code;
    code = 16'h0000;
    st_nxt = st_r;
    st_nxt.char_stb = 1'b0;
    disp_we = 2'h0;
    gam_we = 2'h0;
    cur_we = 2'h0;
    pal_we = 2'h0;
    mem_wdata = {8'h00, BUS.wdata[7:0]};
    // Any access elsewhere means the next port read is a dummy
    if ((BUS.wr || BUS.rd) && BUS.addr != mdp_pkg::A_MDP) begin
      st_nxt.primed = 1'b0;
    end
    if (BUS.wr) begin
      if (BUS.addr == mdp_pkg::A_INCTL) begin
        st_nxt.inctl = BUS.wdata[7:0];
        st_nxt.pal_ptr = '0;
        st_nxt.hi_pend = 1'b0;
      end else if (BUS.addr == mdp_pkg::A_CFG) begin
        st_nxt.cfg = BUS.wdata[7:0];
      end else if (BUS.addr == mdp_pkg::A_PTR_LO) begin
        st_nxt.disp_ptr[7:0] = BUS.wdata[7:0];
      end else if (BUS.addr == mdp_pkg::A_PTR_HI) begin
        st_nxt.disp_ptr[15:8] = BUS.wdata[7:0];
      end else if (BUS.addr == mdp_pkg::A_GAM_SEL) begin
        st_nxt.gam_sel = BUS.wdata[mdp_pkg::GAM_SEL_LSB +: 2];
        st_nxt.gam_ptr = '0;
      end else if (BUS.addr == mdp_pkg::A_CUR_SEL) begin
        st_nxt.cur_sel = BUS.wdata[mdp_pkg::CUR_SEL_LSB +: 2];
        st_nxt.cur_ptr = '0;
      end else if (BUS.addr == mdp_pkg::A_MDP) begin
        // Every write is taken, no wait states and no re-addressing
        case (dest)
          mdp_pkg::DST_DISP: begin
            if (text_mode) begin
              if (st_r.hi_pend) begin
                code = {st_r.hi_byte, BUS.wdata[7:0]};
                st_nxt.hi_pend = 1'b0;
                st_nxt.char_stb = 1'b1;
              end else if (BUS.wdata[mdp_pkg::CHAR_WIDE_BIT]) begin
                st_nxt.hi_byte = BUS.wdata[7:0];
                st_nxt.hi_pend = 1'b1;
              end else begin
                code = {8'h00, BUS.wdata[7:0]};
                st_nxt.char_stb = 1'b1;
              end
              st_nxt.char_code = code;
              st_nxt.char_full = (code >= mdp_pkg::CHAR_FULL_MIN);
            end else begin
              mem_wdata = swap ? {BUS.wdata[7:0], BUS.wdata[15:8]} : BUS.wdata;
              disp_we = (bpa == 2'h2) ? 2'h3 : 2'h1;
              st_nxt.disp_ptr = 16'(st_r.disp_ptr + bpa);
            end
          end
          mdp_pkg::DST_GAMMA: begin
            gam_we = 2'h1;
            st_nxt.gam_ptr = 8'(st_r.gam_ptr + 1'b1);
          end
          mdp_pkg::DST_CURSOR: begin
            cur_we = 2'h1;
            st_nxt.cur_ptr = 8'(st_r.cur_ptr + 1'b1);
          end
          default: begin
            pal_we = 2'h1;
            st_nxt.pal_ptr = 7'(st_r.pal_ptr + 1'b1);
          end
        endcase
      end
    end
    if (BUS.rd) begin
      st_nxt.rdata = 16'h0000;
      if (BUS.addr == mdp_pkg::A_STATUS) begin
        // No write FIFO here, so it always reads empty and idle
        st_nxt.rdata = {8'h00, mdp_pkg::STATUS_IDLE};
      end else if (BUS.addr == mdp_pkg::A_INCTL) begin
        st_nxt.rdata = {8'h00, st_r.inctl};
      end else if (BUS.addr == mdp_pkg::A_CFG) begin
        st_nxt.rdata = {8'h00, st_r.cfg};
      end else if (BUS.addr == mdp_pkg::A_PTR_LO) begin
        st_nxt.rdata = {8'h00, st_r.disp_ptr[7:0]};
      end else if (BUS.addr == mdp_pkg::A_PTR_HI) begin
        st_nxt.rdata = {8'h00, st_r.disp_ptr[15:8]};
      end else if (BUS.addr == mdp_pkg::A_GAM_SEL) begin
        st_nxt.rdata = 16'({st_r.gam_sel, 5'h00});
      end else if (BUS.addr == mdp_pkg::A_CUR_SEL) begin
        st_nxt.rdata = {14'h0000, st_r.cur_sel};
      end else if (BUS.addr == mdp_pkg::A_MDP) begin
        if (!st_r.primed) begin
          st_nxt.rdata = mdp_pkg::DUMMY_DATA;
          st_nxt.primed = 1'b1;
        end else if (dest == mdp_pkg::DST_DISP) begin
          // Aligned word fetch, byte picked by low pointer bits
          st_nxt.rdata = pick_pair(disp_word, st_r.disp_ptr[1:0], swap);
          if (bpa == 2'h1) begin
            st_nxt.rdata[15:8] = 8'h00;
          end
          st_nxt.disp_ptr = 16'(st_r.disp_ptr + bpa);
        end else if (dest == mdp_pkg::DST_GAMMA) begin
          st_nxt.rdata = {8'h00, gam_word[8*st_r.gam_ptr[1:0] +: 8]};
          st_nxt.gam_ptr = 8'(st_r.gam_ptr + 1'b1);
        end
        // Cursor and palette read back as zero, counters hold
      end
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      st_r <= '0;
      st_r.inctl <= mdp_pkg::INCTL_RST;
      st_r.cfg <= mdp_pkg::CFG_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign BUS.rdata = st_r.rdata;
  assign CHAR_STB = st_r.char_stb;
  assign CHAR_CODE = st_r.char_code;
  assign CHAR_FULL = st_r.char_full;
endmodule

// File: common/mdp_pkg.sv
/*
  Shared constants and types of the memory data port: register numbers,
  field positions, reset values, destinations and host sequencer states.
  Assumes both ends are compiled against this one package.
*/
package mdp_pkg;
  // ****************************************
  // Register numbers on the host bus
  // ****************************************
  localparam logic [7:0] A_STATUS = 8'h00;
  localparam logic [7:0] A_INCTL = 8'h03;
  localparam logic [7:0] A_MDP = 8'h04;
  localparam logic [7:0] A_CFG = 8'h10;
  localparam logic [7:0] A_PTR_LO = 8'h11;
  localparam logic [7:0] A_PTR_HI = 8'h12;
  localparam logic [7:0] A_CUR_SEL = 8'h13;
  localparam logic [7:0] A_GAM_SEL = 8'h3C;

  // ****************************************
  // Field positions and values
  // ****************************************
  localparam int INCTL_DST_LSB = 0;
  localparam int INCTL_TEXT_BIT = 2;
  localparam int GAM_SEL_LSB = 5;
  localparam int CUR_SEL_LSB = 0;
  localparam int CFG_BUS16_BIT = 0;
  localparam int CFG_DEPTH_LSB = 1;
  localparam int CFG_BLOCK_BIT = 3;
  localparam int CFG_SWAP_BIT = 4;
  localparam logic [1:0] DEPTH_8BPP = 2'h0;
  localparam logic [7:0] INCTL_RST = 8'h00;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [7:0] STATUS_IDLE = 8'h40;
  localparam int ST_FIFO_EMPTY_BIT = 6;
  localparam logic [15:0] CHAR_FULL_MIN = 16'h8000;
  localparam int CHAR_WIDE_BIT = 7;
  localparam logic [15:0] DUMMY_DATA = 16'h0000;

  // ****************************************
  // Memory sizes (address bits)
  // ****************************************
  localparam int GAM_AW = 10;
  localparam int CUR_AW = 10;
  localparam int PAL_AW = 7;

  // ****************************************
  // Host command port registers
  // ****************************************
  localparam logic [3:0] H_SEL = 4'h0;
  localparam logic [3:0] H_DATA = 4'h1;
  localparam logic [3:0] H_READ = 4'h2;
  localparam logic [3:0] H_STAT = 4'h3;
  localparam logic [3:0] H_CHAR = 4'h4;
  localparam int H_BUSY_BIT = 0;
  localparam int H_VALID_BIT = 1;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    DST_DISP = 2'h0,
    DST_GAMMA = 2'h1,
    DST_CURSOR = 2'h2,
    DST_PAL = 2'h3
  } mdp_dest_t;

  typedef enum logic [2:0] {
    HS_IDLE = 3'h0,
    HS_PRE = 3'h1,
    HS_WAIT = 3'h2,
    HS_CAP = 3'h3,
    HS_CHAR_LO = 3'h4
  } mdp_hstate_t;

  typedef enum logic [1:0] {
    OP_WRITE = 2'h0,
    OP_READ = 2'h1,
    OP_CHAR = 2'h2
  } mdp_op_t;

  typedef enum logic [1:0] {
    PH_POLL = 2'h0,
    PH_DUMMY = 2'h1,
    PH_READ = 2'h2
  } mdp_phase_t;
endpackage

// File: common/mdp_if.sv
/*
  Host bus between the host processor end and the device end.
  Assumes one shared clock; strobes are one cycle, read data one cycle later.
*/
interface mdp_if;
  logic [7:0] addr;
  logic [15:0] wdata;
  logic wr;
  logic rd;
  logic [15:0] rdata;
  modport dev (input addr, input wdata, input wr, input rd, output rdata);
  modport host (output addr, output wdata, output wr, output rd, input rdata);
endinterface

// File: src/mdp_ram.sv
/*
  Byte memory with a two-byte write port and a 4-byte aligned read port.
  Assumes writes never straddle the top of the array.
*/
module mdp_ram #(
  parameter int AW = 8
) (
  // Clock
  input wire logic CLOCK,
  // Write side
  input wire logic [1:0] WE,
  input wire logic [AW-1:0] WADDR,
  input wire logic [15:0] WDATA,
  // Aligned read side
  input wire logic [AW-3:0] RADDR,
  output logic [31:0] RWORD
);
  logic [7:0] mem [0:(1<<AW)-1];

  // Whole word fetched at once, so reads ignore colour depth
  always_comb begin
    RWORD = {mem[{RADDR, 2'h3}], mem[{RADDR, 2'h2}], mem[{RADDR, 2'h1}], mem[{RADDR, 2'h0}]};
  end

  always_ff @(posedge CLOCK) begin
    if (WE[0]) begin
      mem[WADDR] <= WDATA[7:0];
    end
    if (WE[1]) begin
      mem[AW'(WADDR + 1'b1)] <= WDATA[15:8];
    end
  end
endmodule

// File: src/mdp_host.sv
/*
  Host processor end: turns software commands on a plain register port into
  host bus cycles, adding the dummy read and the FIFO-empty poll itself.
  Assumes a device end on the same clock that never stalls.
*/
module mdp_host (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RSTN,
  // Software command port
  input wire logic [3:0] CMD_ADDR,
  input wire logic [15:0] CMD_WDATA,
  input wire logic CMD_WR,
  input wire logic CMD_RD,
  output logic [15:0] CMD_RDATA,
  // Host bus
  mdp_if.host BUS
);
  typedef struct packed {
    mdp_pkg::mdp_hstate_t st;
    mdp_pkg::mdp_op_t op;
    mdp_pkg::mdp_phase_t ph;
    logic [7:0] sel;
    logic [15:0] data;
    logic [7:0] last;
    logic primed;
    logic dirty;
    logic [15:0] result;
    logic valid;
    logic [7:0] baddr;
    logic [15:0] bwdata;
    logic bwr;
    logic brd;
    logic [15:0] crdata;
  } mdp_host_st_t;

  mdp_host_st_t st_r;
  mdp_host_st_t st_nxt;

  // ****************************************
  // Sequencer
  // ****************************************
  always_comb begin
    st_nxt = st_r;
    st_nxt.bwr = 1'b0;
    st_nxt.brd = 1'b0;
    if (CMD_RD) begin
      st_nxt.crdata = 16'h0000;
      if (CMD_ADDR == mdp_pkg::H_SEL) begin
        st_nxt.crdata = {8'h00, st_r.sel};
      end else if (CMD_ADDR == mdp_pkg::H_DATA) begin
        st_nxt.crdata = st_r.result;
      end else if (CMD_ADDR == mdp_pkg::H_STAT) begin
        st_nxt.crdata[mdp_pkg::H_BUSY_BIT] = (st_r.st != mdp_pkg::HS_IDLE);
        st_nxt.crdata[mdp_pkg::H_VALID_BIT] = st_r.valid;
      end
    end
    case (st_r.st)
      mdp_pkg::HS_IDLE: begin
        // Commands that arrive while busy are dropped
        if (CMD_WR) begin
          st_nxt.data = CMD_WDATA;
          if (CMD_ADDR == mdp_pkg::H_SEL) begin
            st_nxt.sel = CMD_WDATA[7:0];
          end else if (CMD_ADDR == mdp_pkg::H_DATA) begin
            st_nxt.op = mdp_pkg::OP_WRITE;
            st_nxt.st = mdp_pkg::HS_PRE;
          end else if (CMD_ADDR == mdp_pkg::H_READ) begin
            st_nxt.op = mdp_pkg::OP_READ;
            st_nxt.valid = 1'b0;
            st_nxt.st = mdp_pkg::HS_PRE;
          end else if (CMD_ADDR == mdp_pkg::H_CHAR) begin
            st_nxt.op = mdp_pkg::OP_CHAR;
            st_nxt.st = mdp_pkg::HS_PRE;
          end
        end
      end
      mdp_pkg::HS_PRE: begin
        if (st_r.dirty && st_r.last == mdp_pkg::A_MDP && st_r.sel != mdp_pkg::A_MDP) begin
          // Leaving the port after any port writes: poll until FIFO empty reads set, then proceed
          st_nxt.baddr = mdp_pkg::A_STATUS;
          st_nxt.brd = 1'b1;
          st_nxt.ph = mdp_pkg::PH_POLL;
          st_nxt.st = mdp_pkg::HS_WAIT;
        end else if (st_r.op == mdp_pkg::OP_READ && st_r.sel == mdp_pkg::A_MDP &&
                     !(st_r.primed && st_r.last == mdp_pkg::A_MDP)) begin
          st_nxt.baddr = mdp_pkg::A_MDP;
          st_nxt.brd = 1'b1;
          st_nxt.ph = mdp_pkg::PH_DUMMY;
          st_nxt.st = mdp_pkg::HS_WAIT;
        end else if (st_r.op == mdp_pkg::OP_READ) begin
          st_nxt.baddr = st_r.sel;
          st_nxt.brd = 1'b1;
          st_nxt.ph = mdp_pkg::PH_READ;
          st_nxt.st = mdp_pkg::HS_WAIT;
        end else begin
          // Same address kept, so port runs stay continuous
          st_nxt.baddr = st_r.sel;
          st_nxt.bwr = 1'b1;
          st_nxt.dirty = st_r.dirty | (st_r.sel == mdp_pkg::A_MDP);
          if (st_r.op == mdp_pkg::OP_CHAR) begin
            st_nxt.bwdata = {8'h00, st_r.data[15:8]};
            st_nxt.st = mdp_pkg::HS_CHAR_LO;
          end else begin
            st_nxt.bwdata = st_r.data;
            st_nxt.st = mdp_pkg::HS_IDLE;
          end
        end
        st_nxt.last = st_nxt.baddr;
        if (st_nxt.baddr != mdp_pkg::A_MDP) begin
          st_nxt.primed = 1'b0;
        end
      end
      mdp_pkg::HS_WAIT: begin
        st_nxt.st = mdp_pkg::HS_CAP;
      end
      mdp_pkg::HS_CAP: begin
        st_nxt.st = mdp_pkg::HS_PRE;
        if (st_r.ph == mdp_pkg::PH_POLL) begin
          st_nxt.dirty = !BUS.rdata[mdp_pkg::ST_FIFO_EMPTY_BIT];
        end else if (st_r.ph == mdp_pkg::PH_DUMMY) begin
          st_nxt.primed = 1'b1; // Data discarded
        end else begin
          st_nxt.result = BUS.rdata;
          st_nxt.valid = 1'b1;
          st_nxt.st = mdp_pkg::HS_IDLE;
        end
      end
      default: begin
        st_nxt.bwr = 1'b1;
        st_nxt.bwdata = {8'h00, st_r.data[7:0]};
        st_nxt.st = mdp_pkg::HS_IDLE;
      end
    endcase
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      st_r <= '0;
      st_r.st <= mdp_pkg::HS_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign BUS.addr = st_r.baddr;
  assign BUS.wdata = st_r.bwdata;
  assign BUS.wr = st_r.bwr;
  assign BUS.rd = st_r.brd;
  assign CMD_RDATA = st_r.crdata;
endmodule

// File: test/mdp_sva.sv
/*
  Checker of the host bus between the host end and the device end.
  Assumes it watches the one interface instance that joins both ends.
*/
module mdp_sva (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RSTN,
  // Host bus
  input wire logic [7:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [15:0] rdata,
  // Character stream
  input wire logic CHAR_STB,
  input wire logic [15:0] CHAR_CODE,
  input wire logic CHAR_FULL
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // Helper state
  // ****************************************
  logic [7:0] last_r;
  logic [1:0] dst_r;
  logic dirty_r;
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RSTN);
  // Port writes leave the dummy condition alone, so they do not count as readdressing
  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      last_r <= 8'h00;
      dst_r <= 2'h0;
      dirty_r <= 1'b0;
    end else begin
      if ((wr || rd) && !(wr && addr == mdp_pkg::A_MDP)) last_r <= addr;
      if (wr && addr == mdp_pkg::A_INCTL) dst_r <= wdata[1:0];
      if (wr && addr == mdp_pkg::A_MDP && dst_r == mdp_pkg::DST_DISP) dirty_r <= 1'b1;
      else if (rd && addr == mdp_pkg::A_STATUS) dirty_r <= 1'b0;
    end
  end
  // ****************************************
  // Assertions
  // ****************************************
  strobes_exclusive_a: assert property (!(wr && rd))
    else $error("write and read strobes together");
  dummy_read_a: assert property (
    rd && addr == mdp_pkg::A_MDP && last_r != mdp_pkg::A_MDP |=> rdata == mdp_pkg::DUMMY_DATA)
    else $error("first port read not dummy");
  write_only_a: assert property (rd && addr == mdp_pkg::A_MDP && dst_r[1] |=> rdata == 16'h0000)
    else $error("cursor or palette read returned data");
  status_idle_a: assert property (
    rd && addr == mdp_pkg::A_STATUS |=> rdata[7:0] == mdp_pkg::STATUS_IDLE)
    else $error("status not idle");
  leave_poll_a: assert property (
    (wr || rd) && dirty_r |-> addr == mdp_pkg::A_MDP || addr == mdp_pkg::A_STATUS)
    else $error("address changed before fifo empty poll");
  rdata_hold_a: assert property (!rd |=> $stable(rdata))
    else $error("read data moved without a read");
  char_size_a: assert property (
    CHAR_STB |-> CHAR_FULL == (CHAR_CODE >= mdp_pkg::CHAR_FULL_MIN))
    else $error("glyph size flag wrong");
  char_source_a: assert property (CHAR_STB |-> $past(wr) && $past(addr) == mdp_pkg::A_MDP
    && ($past(wdata) & 16'h00FF) == {8'h00, CHAR_CODE[7:0]})
    else $error("character code not from low port byte");
endmodule

// File: test/tb.sv
/*
  Testbench: software commands drive the host end, which talks to the
  device end over the shared interface. Assumes one clock for both ends.
*/
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic CLOCK = 1'b0;
  logic RSTN = 1'b0;
  logic [3:0] CMD_ADDR = 4'h0;
  logic [15:0] CMD_WDATA = 16'h0000;
  logic CMD_WR = 1'b0;
  logic CMD_RD = 1'b0;
  logic [15:0] CMD_RDATA;
  logic CHAR_STB;
  logic [15:0] CHAR_CODE;
  logic CHAR_FULL;
  logic [15:0] last_code = 16'h0000;
  logic last_full = 1'b0;
  logic [15:0] v;
  int error_cnt = 0;
  int n_compared = 0;
  int cycles = 0;
  int char_cnt = 0;
  mdp_if bus_if();
  // Small display array keeps the memory light
  mdp_dev #(.DAW(8)) mdp_dev_i (.CLOCK(CLOCK), .RSTN(RSTN), .BUS(bus_if), .CHAR_STB(CHAR_STB),
    .CHAR_CODE(CHAR_CODE), .CHAR_FULL(CHAR_FULL));
  mdp_host mdp_host_i (.CLOCK(CLOCK), .RSTN(RSTN), .CMD_ADDR(CMD_ADDR), .CMD_WDATA(CMD_WDATA),
    .CMD_WR(CMD_WR), .CMD_RD(CMD_RD), .CMD_RDATA(CMD_RDATA), .BUS(bus_if));
  mdp_sva mdp_sva_i (.CLOCK(CLOCK), .RSTN(RSTN), .addr(bus_if.addr), .wdata(bus_if.wdata),
    .wr(bus_if.wr), .rd(bus_if.rd), .rdata(bus_if.rdata), .CHAR_STB(CHAR_STB),
    .CHAR_CODE(CHAR_CODE), .CHAR_FULL(CHAR_FULL));
  always #50 CLOCK = ~CLOCK;
  // ****************************************
  // Watchdog and character monitor
  // ****************************************
  always @(posedge CLOCK) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      stop_test();
    end
  end
  // Mid-cycle sampling avoids racing the strobe flop
  always @(negedge CLOCK) begin
    if (CHAR_STB === 1'b1) begin
      char_cnt++;
      last_code = CHAR_CODE;
      last_full = CHAR_FULL;
    end
  end
  // ****************************************
  // Driver and compare tasks
  // ****************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmd_wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge CLOCK);
    CMD_ADDR <= a;
    CMD_WDATA <= d;
    CMD_WR <= 1'b1;
    @(posedge CLOCK);
    CMD_WR <= 1'b0;
  endtask
  task automatic cmd_rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge CLOCK);
    CMD_ADDR <= a;
    CMD_RD <= 1'b1;
    @(posedge CLOCK);
    CMD_RD <= 1'b0;
    #1 d = CMD_RDATA;
  endtask
  task automatic wait_done(input logic need);
    logic [15:0] s;
    for (int i = 0; i < 100; i++) begin
      cmd_rd(mdp_pkg::H_STAT, s);
      if (s[mdp_pkg::H_BUSY_BIT] === 1'b0 && (!need || s[mdp_pkg::H_VALID_BIT] === 1'b1)) break;
    end
    chk({15'h0000, s[mdp_pkg::H_BUSY_BIT]}, 16'h0000);
  endtask
  task automatic sel(input logic [7:0] r);
    cmd_wr(mdp_pkg::H_SEL, {8'h00, r});
  endtask
  task automatic put(input logic [15:0] d);
    cmd_wr(mdp_pkg::H_DATA, d);
    wait_done(1'b0);
  endtask
  task automatic get(output logic [15:0] d);
    cmd_wr(mdp_pkg::H_READ, 16'h0000);
    wait_done(1'b1);
    cmd_rd(mdp_pkg::H_DATA, d);
  endtask
  task automatic dev_wr(input logic [7:0] r, input logic [15:0] d);
    sel(r);
    put(d);
  endtask
  task automatic dev_rd(input logic [7:0] r, output logic [15:0] d);
    sel(r);
    get(d);
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_regs();
    dev_rd(mdp_pkg::A_STATUS, v);
    chk({8'h00, v[7:0]}, {8'h00, mdp_pkg::STATUS_IDLE});
    dev_rd(mdp_pkg::A_INCTL, v);
    chk({8'h00, v[7:0]}, {8'h00, mdp_pkg::INCTL_RST});
    dev_rd(mdp_pkg::A_CFG, v);
    chk({8'h00, v[7:0]}, {8'h00, mdp_pkg::CFG_RST});
    dev_rd(8'h7F, v);
    chk(v, 16'h0000);
  endtask
  task automatic t_gamma();
    dev_wr(mdp_pkg::A_INCTL, 16'(mdp_pkg::DST_GAMMA));
    dev_wr(mdp_pkg::A_GAM_SEL, 16'h0020);
    sel(mdp_pkg::A_MDP);
    for (int i = 0; i < 8; i++) put({8'hFF, 8'(8'h10 + i)});
    dev_wr(mdp_pkg::A_GAM_SEL, 16'h0020);
    sel(mdp_pkg::A_MDP);
    for (int i = 0; i < 8; i++) begin
      get(v);
      chk({8'h00, v[7:0]}, {8'h00, 8'(8'h10 + i)});
    end
  endtask
  task automatic t_write_only();
    dev_wr(mdp_pkg::A_INCTL, 16'(mdp_pkg::DST_CURSOR));
    dev_wr(mdp_pkg::A_CUR_SEL, 16'h0001);
    sel(mdp_pkg::A_MDP);
    for (int i = 0; i < 4; i++) put(16'hAAC0 + 16'(i));
    get(v);
    chk(v, 16'h0000);
    dev_wr(mdp_pkg::A_INCTL, 16'(mdp_pkg::DST_PAL));
    sel(mdp_pkg::A_MDP);
    // Nonzero first entry, so a leaked read-back would show
    for (int i = 0; i < 128; i++) put(16'(i) ^ 16'h005A);
    get(v);
    chk(v, 16'h0000);
  endtask
  task automatic t_display();
    logic [7:0] exp_b [8] = '{8'h31, 8'h32, 8'h33, 8'h34, 8'hEF, 8'hBE, 8'h12, 8'h34};
    dev_wr(mdp_pkg::A_CFG, 16'h0000);
    dev_wr(mdp_pkg::A_INCTL, 16'(mdp_pkg::DST_DISP));
    dev_wr(mdp_pkg::A_PTR_HI, 16'h0000);
    dev_wr(mdp_pkg::A_PTR_LO, 16'h0010);
    sel(mdp_pkg::A_MDP);
    for (int i = 0; i < 4; i++) put({8'hFF, 8'(8'h31 + i)});
    dev_wr(mdp_pkg::A_CFG, 16'h0003);
    dev_wr(mdp_pkg::A_PTR_LO, 16'h0020);
    sel(mdp_pkg::A_MDP);
    put(16'hBEEF);
    dev_wr(mdp_pkg::A_CFG, 16'h0013);
    dev_wr(mdp_pkg::A_PTR_LO, 16'h0022);
    sel(mdp_pkg::A_MDP);
    put(16'h1234);
    dev_wr(mdp_pkg::A_CFG, 16'h0000);
    for (int j = 0; j < 2; j++) begin
      dev_wr(mdp_pkg::A_PTR_LO, (j == 0) ? 16'h0010 : 16'h0020);
      sel(mdp_pkg::A_MDP);
      for (int i = 0; i < 4; i++) begin
        get(v);
        chk({8'h00, v[7:0]}, {8'h00, exp_b[j * 4 + i]});
      end
    end
  endtask
  task automatic t_char();
    int c0;
    dev_wr(mdp_pkg::A_CFG, 16'h0008);
    dev_wr(mdp_pkg::A_INCTL, 16'h0004);
    // Character bytes must go to the port, not to the last register
    sel(mdp_pkg::A_MDP);
    c0 = char_cnt;
    cmd_wr(mdp_pkg::H_CHAR, 16'h8123);
    wait_done(1'b0);
    // Strobe lands after the host goes idle
    repeat (2) @(posedge CLOCK);
    chk(16'(char_cnt - c0), 16'h0001);
    chk(last_code, 16'h8123);
    chk({15'h0000, last_full}, 16'h0001);
    put(16'hFF41);
    repeat (2) @(posedge CLOCK);
    chk(last_code, 16'h0041);
    chk({15'h0000, last_full}, 16'h0000);
    c0 = char_cnt;
    dev_wr(mdp_pkg::A_CFG, 16'h0000);
    sel(mdp_pkg::A_MDP);
    put(16'h0042);
    repeat (2) @(posedge CLOCK);
    chk(16'(char_cnt - c0), 16'h0000);
  endtask
  task automatic t_reset();
    dev_wr(mdp_pkg::A_INCTL, 16'h0003);
    @(posedge CLOCK);
    RSTN <= 1'b0;
    repeat (8) @(posedge CLOCK);
    RSTN <= 1'b1;
    dev_rd(mdp_pkg::A_INCTL, v);
    chk({8'h00, v[7:0]}, {8'h00, mdp_pkg::INCTL_RST});
  endtask
  task automatic stop_test();
    $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge CLOCK);
    RSTN <= 1'b1;
    t_regs();
    t_gamma();
    t_write_only();
    t_display();
    t_char();
    t_reset();
    stop_test();
  end
endmodule
